// [dma_chain_next_address_regs.sv]
// Next-buffer address registers for the chaining channels 3, 5, 6 and 7.
`include "chain_addr_consts.svh"
`default_nettype none

// What this block does
// - Low register holds address bits 15..0.
// - High register bits 11..0 hold bits 27..16.
// - Next address ignored unless chaining enabled.
// - Bit 0 ignored in 16-bit transfer mode.
// - End with valid set: reload, clear valid.
// - End without valid: assert terminal count.
module dma_chain_next_address_regs
    import chain_addr_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire reg_req_type req_i,
    input wire chan_ctrl_type [`CHAN_COUNT-1:0] ctrl_i,
    output logic [15:0] rdata_o,
    output logic rvalid_o,
    output chan_load_type [`CHAN_COUNT-1:0] load_o
);

    // ============================================================
    // Register storage and registered outputs.
    logic [`LO_FIELD_MSB:0] lo_q [`CHAN_COUNT];
    logic [`HI_FIELD_MSB:0] hi_q [`CHAN_COUNT];
    logic [`LO_FIELD_MSB:0] rdata_d;
    logic [`NEXT_ADDR_MSB:0] next_addr_q [`CHAN_COUNT];
    logic [`CHAN_COUNT-1:0] reload_q;
    logic [`CHAN_COUNT-1:0] valid_clear_q;
    logic [`CHAN_COUNT-1:0] term_count_q;

    // ============================================================
    // Register offsets of each channel.
    function automatic logic [11:0] lo_ofs(input int ch);
        logic [11:0] r;
        r = `CH3_ADDR_LO_OFS;
        unique case (ch)
            0: r = `CH3_ADDR_LO_OFS;
            1: r = `CH5_ADDR_LO_OFS;
            2: r = `CH6_ADDR_LO_OFS;
            3: r = `CH7_ADDR_LO_OFS;
            default: r = `CH3_ADDR_LO_OFS;
        endcase
        return r;
    endfunction

    function automatic logic [11:0] hi_ofs(input int ch);
        logic [11:0] r;
        r = `CH3_ADDR_HI_OFS;
        unique case (ch)
            0: r = `CH3_ADDR_HI_OFS;
            1: r = `CH5_ADDR_HI_OFS;
            2: r = `CH6_ADDR_HI_OFS;
            3: r = `CH7_ADDR_HI_OFS;
            default: r = `CH3_ADDR_HI_OFS;
        endcase
        return r;
    endfunction

    // ============================================================
    // Address and field decode.
    function automatic logic lo_hit(
        input logic [11:0] addr,
        input int ch
    );
        return addr == lo_ofs(ch);
    endfunction

    function automatic logic hi_hit(
        input logic [11:0] addr,
        input int ch
    );
        return addr == hi_ofs(ch);
    endfunction

    function automatic logic [`HI_FIELD_MSB:0] hi_field(
        input logic [`LO_FIELD_MSB:0] wdata
    );
        return wdata[`HI_FIELD_MSB:0];
    endfunction

    function automatic logic [`LO_FIELD_MSB:0] hi_readback(
        input logic [`HI_FIELD_MSB:0] hi
    );
        return {`RSV_ZERO, hi};
    endfunction

    // ============================================================
    // Chain decisions.
    function automatic logic [`NEXT_ADDR_MSB:0] join_addr(
        input logic [`HI_FIELD_MSB:0] hi,
        input logic [`LO_FIELD_MSB:0] lo,
        input logic width16
    );
        return {hi, lo[`LO_FIELD_MSB:`LO_KEPT_LSB], lo[`ODD_BIT] & ~width16};
    endfunction

    function automatic logic reload_due(input chan_ctrl_type c);
        return c.chain_enable & c.end_of_buffer & c.next_valid;
    endfunction

    function automatic logic term_due(input chan_ctrl_type c);
        return c.chain_enable & c.end_of_buffer & ~c.next_valid;
    endfunction

    // ============================================================
    // Low register writes.
    always_ff @(posedge clk_i) begin
        for (int ch = 0; ch < `CHAN_COUNT; ch++) begin
            if (rst_i) begin
                lo_q[ch] <= `ADDR_LO_RESET;
            end else if (req_i.wr_en && lo_hit(req_i.addr, ch)) begin
                lo_q[ch] <= req_i.wdata;
            end
        end
    end

    // ============================================================
    // High register writes, reserved bits are dropped.
    always_ff @(posedge clk_i) begin
        for (int ch = 0; ch < `CHAN_COUNT; ch++) begin
            if (rst_i) begin
                hi_q[ch] <= `ADDR_HI_RESET;
            end else if (req_i.wr_en && hi_hit(req_i.addr, ch)) begin
                hi_q[ch] <= hi_field(req_i.wdata);
            end
        end
    end

    // ============================================================
    // Read selection, reserved bits return zero.
    always_comb begin
        rdata_d = `READ_ZERO;
        for (int ch = 0; ch < `CHAN_COUNT; ch++) begin
            if (lo_hit(req_i.addr, ch)) begin
                rdata_d = lo_q[ch];
            end
            if (hi_hit(req_i.addr, ch)) begin
                rdata_d = hi_readback(hi_q[ch]);
            end
        end
    end

    // ============================================================
    // Read data register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= `READ_ZERO;
        end else if (req_i.rd_en) begin
            rdata_o <= rdata_d;
        end else begin
            rdata_o <= `READ_ZERO;
        end
    end

    // ============================================================
    // Read valid register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rvalid_o <= `FLAG_RESET;
        end else begin
            rvalid_o <= req_i.rd_en;
        end
    end

    // ============================================================
    // Next buffer address of each channel.
    always_ff @(posedge clk_i) begin
        for (int ch = 0; ch < `CHAN_COUNT; ch++) begin
            if (rst_i) begin
                next_addr_q[ch] <= `ADDR_NEXT_RESET;
            end else begin
                next_addr_q[ch] <= join_addr(hi_q[ch], lo_q[ch], ctrl_i[ch].width16);
            end
        end
    end

    // ============================================================
    // Reload pulse at the end of a buffer.
    always_ff @(posedge clk_i) begin
        for (int ch = 0; ch < `CHAN_COUNT; ch++) begin
            if (rst_i) begin
                reload_q[ch] <= `FLAG_RESET;
            end else begin
                reload_q[ch] <= reload_due(ctrl_i[ch]);
            end
        end
    end

    // ============================================================
    // Valid clear request, given with the reload.
    always_ff @(posedge clk_i) begin
        for (int ch = 0; ch < `CHAN_COUNT; ch++) begin
            if (rst_i) begin
                valid_clear_q[ch] <= `FLAG_RESET;
            end else begin
                valid_clear_q[ch] <= reload_due(ctrl_i[ch]);
            end
        end
    end

    // ============================================================
    // Terminal count when no valid next buffer waits.
    always_ff @(posedge clk_i) begin
        for (int ch = 0; ch < `CHAN_COUNT; ch++) begin
            if (rst_i) begin
                term_count_q[ch] <= `FLAG_RESET;
            end else begin
                term_count_q[ch] <= term_due(ctrl_i[ch]);
            end
        end
    end

    // ============================================================
    // Output bundle, each field straight from its register.
    always_comb begin
        load_o = '0;
        for (int ch = 0; ch < `CHAN_COUNT; ch++) begin
            load_o[ch].reload = reload_q[ch];
            load_o[ch].terminal_count = term_count_q[ch];
            load_o[ch].valid_clear = valid_clear_q[ch];
            load_o[ch].next_addr = next_addr_q[ch];
        end
    end

endmodule
`default_nettype wire

// [chain_addr_consts.svh]
// Offsets, field positions and reset values of the next-buffer address registers.
`ifndef CHAIN_ADDR_CONSTS_SVH
`define CHAIN_ADDR_CONSTS_SVH
`define CH3_ADDR_LO_OFS 12'h0da0
`define CH3_ADDR_HI_OFS 12'h0da2
`define CH5_ADDR_LO_OFS 12'h0da4
`define CH5_ADDR_HI_OFS 12'h0da6
`define CH6_ADDR_LO_OFS 12'h0da8
`define CH6_ADDR_HI_OFS 12'h0daa
`define CH7_ADDR_LO_OFS 12'h0dac
`define CH7_ADDR_HI_OFS 12'h0dae
`define CHAN_COUNT 4
`define HI_FIELD_MSB 11
`define LO_FIELD_MSB 15
`define LO_KEPT_LSB 1
`define ODD_BIT 0
`define NEXT_ADDR_MSB 27
`define ADDR_NEXT_RESET 28'h000_0000
`define FLAG_RESET 1'b0
`define ADDR_LO_RESET 16'h0000
`define ADDR_HI_RESET 12'h000
`define READ_ZERO 16'h0000
`define RSV_ZERO 4'h0
`endif

// [chain_addr_pkg.sv]
// Types shared by the next-buffer address register block.
`default_nettype none
package chain_addr_pkg;
    typedef struct packed {
        logic        wr_en;
        logic        rd_en;
        logic [11:0] addr;
        logic [15:0] wdata;
    } reg_req_type;

    typedef struct packed {
        logic        chain_enable;
        logic        next_valid;
        logic        width16;
        logic        end_of_buffer;
    } chan_ctrl_type;

    typedef struct packed {
        logic        reload;
        logic        terminal_count;
        logic        valid_clear;
        logic [27:0] next_addr;
    } chan_load_type;
endpackage
`default_nettype wire

// [chain_regs_assertions.sv]
// Checker for the next-buffer address registers.
`default_nettype none
// ====
// Checker.
module chain_regs_assertions
    import chain_addr_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire reg_req_type req_i,
    input wire chan_ctrl_type [3:0] ctrl_i,
    input wire logic [15:0] rdata_o,
    input wire logic rvalid_o,
    input wire chan_load_type [3:0] load_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_read_answer: assert property (req_i.rd_en |=> rvalid_o)
        else $error("read answer missing");
    chk_high_spare: assert property (req_i.rd_en && req_i.addr[1] |=> rdata_o[15:12] == 4'h0)
        else $error("spare high bits set");
    chk_chain_off: assert property (!ctrl_i[0].chain_enable |=> !load_o[0].reload
        && !load_o[0].terminal_count) else $error("pulse while chaining off");
    chk_even_addr: assert property (ctrl_i[0].width16 |=> !load_o[0].next_addr[0])
        else $error("odd address in wide mode");
    chk_reload_clear: assert property (ctrl_i[0].end_of_buffer && ctrl_i[0].chain_enable
        && ctrl_i[0].next_valid |=> load_o[0].reload && load_o[0].valid_clear)
        else $error("reload missing");
    chk_term_count: assert property (ctrl_i[0].end_of_buffer && ctrl_i[0].chain_enable
        && !ctrl_i[0].next_valid |=> load_o[0].terminal_count && !load_o[0].reload)
        else $error("terminal count missing");
    chk_addr_join: assert property (req_i.wr_en && req_i.addr == 12'h0da0 |=> ##1
        load_o[0].next_addr[15:1] == $past(req_i.wdata[15:1], 2)) else $error("low field lost");
endmodule
bind dma_chain_next_address_regs chain_regs_assertions i_chk (.clk_i(clk_i), .rst_i(rst_i),
    .req_i(req_i), .ctrl_i(ctrl_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .load_o(load_o));
`default_nettype wire

// [tb.sv]
// Self-checking bench for the next-buffer address registers.
`default_nettype none
// ====
// Bench.
module tb;
    import chain_addr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0;
    logic rst_i = 1;
    reg_req_type req_i = '0;
    chan_ctrl_type [3:0] ctrl_i = '0;
    logic [15:0] rdata_o;
    logic rvalid_o;
    chan_load_type [3:0] load_o;
    int err_total = 0, cmp_count = 0, seed = 84, cyc = 0;
    int mdl [8];
    dma_chain_next_address_regs i_dma_chain_next_address_regs (.clk_i(clk_i), .rst_i(rst_i),
        .req_i(req_i), .ctrl_i(ctrl_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .load_o(load_o));
    always #2 clk_i = ~clk_i;
    task automatic check(string n, logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic close_out();
        $display("mismatches %0d compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic access(logic wr, logic [11:0] a, logic [15:0] d);
        @(posedge clk_i);
        req_i <= {wr, ~wr, a, d};
        @(posedge clk_i);
        req_i <= '0;
        #1;
        check("rvalid", !wr, rvalid_o);
        check("rdata", !wr && a < 12'h0db0 ? mdl[a[3:1]] : 0, rdata_o);
    endtask
    task automatic link(int c, logic [2:0] m);
        @(posedge clk_i);
        ctrl_i[c] <= {m, 1'b1};
        @(posedge clk_i);
        ctrl_i[c].end_of_buffer <= 1'b0;
        #1;
        check("load", {m[2] & m[1], m[2] & !m[1], m[2] & m[1], mdl[2 * c + 1][11:0],
            mdl[2 * c][15:1], mdl[2 * c][0] & !m[0]}, load_o[c]);
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 2000) begin
            err_total++;
            close_out();
        end
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 0;
        for (int i = 0; i < 8; i++) begin
            mdl[i] = $random(seed) & (i[0] ? 32'h0000_0fff : 32'h0000_ffff);
            access(1, 12'h0da0 + 12'(2 * i), 16'(mdl[i]));
            access(0, 12'h0da0 + 12'(2 * i), 16'h0000);
        end
        access(1, 12'h0db0, 16'hffff);
        access(0, 12'h0db0, 16'h0000);
        for (int c = 0; c < 4; c++)
            for (int m = 0; m < 8; m++)
                link(c, 3'(m));
        mdl[0] = $random(seed) & 32'h0000_fffe;
        access(1, 12'h0da0, 16'(mdl[0]));
        link(0, 3'h7);
        @(posedge clk_i);
        rst_i <= 1;
        @(posedge clk_i);
        rst_i <= 0;
        for (int i = 0; i < 8; i++) begin
            mdl[i] = 0;
            access(0, 12'h0da0 + 12'(2 * i), 16'h0000);
        end
        close_out();
    end
endmodule
`default_nettype wire
